// file: ccc_defs.vh
// Constants for the clock conditioner configuration block
`ifndef CCC_DEFS_VH
`define CCC_DEFS_VH
`define CCC_CFG_BITS      89
`define CCC_BASE_BITS     81
`define CCC_DC1_LO        71
`define CCC_DC1_HI        73
`define CCC_DC2_LO        77
`define CCC_DC2_HI        80
`define CCC_HALF_A        84
`define CCC_HALF_B        85
`define CCC_HALF_C        86
`define CCC_GMUX_LO       87
`define CCC_GMUX_HI       88
`define CCC_SRC_A_LO      0
`define CCC_SRC_B_LO      2
`define CCC_SRC_C_LO      4
`define CCC_PIN_A_LO      6
`define CCC_PIN_B_LO      8
`define CCC_PIN_C_LO      10
`define CCC_PLL_EN        12
`define CCC_EN_GLB        13
`define CCC_EN_YB         14
`define CCC_EN_GLC        15
`define CCC_EN_YC         16
`define CCC_DLY_GLA_LO    17
`define CCC_DLY_GLB_LO    21
`define CCC_DLY_GLC_LO    25
`define CCC_DLY_YB_LO     29
`define CCC_DLY_YC_LO     35
`define CCC_FB_DLY_LO     41
`define CCC_SRC_SE        2'h0
`define CCC_SRC_DIFF      2'h1
`define CCC_SRC_CORE      2'h2
`endif

// file: ccc_config.v
// Clock conditioner run-time configuration register and output steering
//
// Summary of operation
// - Three global outputs A, B, C
// - Each global input picks one of three single-ended or two differential pins
// - Source: single-ended, differential or core
// - PLL reference from input A, drives A
// - Core B/C in use blocks global reuse
// - Core outputs carry longer selectable delay
// - Five phase delays plus feedback advance delay
// - Hold sleep low while reference static
// - Shift ends, then update applies config
// - Bits 71-73 and 77-80 ignored
// - Bits 88:87 pick glitchless mux inputs
// - Bits 84-86 enable oscillator half division with PLL bypassed
// - Bits 81-88 only in extended variant
// - Serial asynchronous run-time access path
`timescale 1ns/1ps
`include "ccc_defs.vh"

module ccc_config #(
   parameter EXTENDED  = 1,                     // Extended variant with bits 81..88
   parameter SE_PINS   = 3,                     // Dedicated single-ended inputs
   parameter DIFF_PINS = 2                      // Dedicated differential inputs
)(
   input  wire        clk,
   input  wire        srst,
   input  wire        serial_config_in,
   input  wire        shift_enable,
   input  wire        update_strobe,
   input  wire        pll_sleep_n,
   input  wire [2:0]  ref_clock_in_a,
   input  wire [2:0]  clock_in_b,
   input  wire [2:0]  clock_in_c,
   input  wire [1:0]  diff_in_a,
   input  wire [1:0]  diff_in_b,
   input  wire [1:0]  diff_in_c,
   input  wire        core_clk_a,
   input  wire        core_clk_b,
   input  wire        core_clk_c,
   input  wire        pll_clk,
   input  wire        osc_clk,
   output reg         global_out_a,
   output reg         global_out_b,
   output reg         global_out_c,
   output reg         core_out_b,
   output reg         core_out_c,
   output reg  [3:0]  dly_global_a,
   output reg  [3:0]  dly_global_b,
   output reg  [3:0]  dly_global_c,
   output reg  [5:0]  dly_core_b,
   output reg  [5:0]  dly_core_c,
   output reg  [3:0]  dly_feedback,
   output reg  [1:0]  output_mux_select,
   output reg         osc_half_div_a,
   output reg         osc_half_div_b,
   output reg         osc_half_div_c,
   output reg         pll_run,
   output reg         grouping_err
);

   localparam NB = `CCC_CFG_BITS;               // Shift chain length
   localparam [1:0] ST_IDLE  = 2'h0;            // No shifting seen
   localparam [1:0] ST_SHIFT = 2'h1;            // Shifting in progress
   localparam [1:0] ST_READY = 2'h2;            // Shift done, awaiting update

   // Timing counted from the pin edges
   // Two synchroniser stages, then one edge to detect the update
   // Active word moves three clocks after the update pin rises
   // Registered outputs follow one clock after the active word
   // Data and shift enable share one path, so bits stay aligned

   // Synchronisers for the asynchronous serial port pins
   reg  [2:0]    meta_r;                        // First stage
   reg  [2:0]    sync_r;                        // Second stage
   reg           upd_d_r;                       // Update edge detector
   wire          sdi   = sync_r[0];             // Synchronised data
   wire          sen   = sync_r[1];             // Synchronised shift enable
   wire          supd  = sync_r[2];             // Synchronised update
   wire          upd_rise = supd & ~upd_d_r;    // One update per strobe

   reg  [NB-1:0] shift_r;                       // Serial shift register
   reg  [NB-1:0] cfg_r;                         // Active configuration
   reg  [NB-1:0] cfg_nxt;                       // Masked shadow value
   reg  [1:0]    state_r;                       // Loader sequence tracking
   reg  [1:0]    state_nxt;

   // Pin synchronisers: the loader is not timed to this clock
   // Each pin passes two flops before any logic reads it
   // Only the second stage is read; the first may be metastable
   always @(posedge clk)
   begin
      if (srst)
      begin
         meta_r  <= 3'h0;
         sync_r  <= 3'h0;
         upd_d_r <= 1'b0;
      end
      else
      begin
         meta_r  <= {update_strobe, shift_enable, serial_config_in};
         sync_r  <= meta_r;
         upd_d_r <= supd;
      end
   end

   // Shift register: MSB enters first, one bit per enabled clock
   // Held while shift is low, so a moving data line is harmless
   always @(posedge clk)
   begin
      if (srst)
         shift_r <= {NB{1'b0}};
      else if (sen)
         shift_r <= {shift_r[NB-2:0], sdi};
   end

   // Shadow mask: don't-care fields and absent extended bits cleared
   // Cleared bits keep the ignored fields deterministic
   genvar gi;
   generate
      for (gi = 0; gi < NB; gi = gi + 1)
      begin : g_mask
         always @*
         begin
            if ((gi >= `CCC_DC1_LO && gi <= `CCC_DC1_HI) ||
                (gi >= `CCC_DC2_LO && gi <= `CCC_DC2_HI))
               cfg_nxt[gi] = 1'b0;
            else if (gi >= `CCC_BASE_BITS && EXTENDED == 0)
               cfg_nxt[gi] = 1'b0;
            else
               cfg_nxt[gi] = shift_r[gi];
         end
      end
   endgenerate

   // Loader sequence: update honoured only after a finished frame
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            // First shifted bit opens a frame
            if (sen)
               state_nxt = ST_SHIFT;
         end
         ST_SHIFT:
         begin
            // Shift dropped: frame complete, update now allowed
            if (!sen)
               state_nxt = ST_READY;
         end
         ST_READY:
         begin
            // A fresh shift restarts the frame; an update closes it
            if (sen)
               state_nxt = ST_SHIFT;
            else if (upd_rise)
               state_nxt = ST_IDLE;
         end
         default:
            state_nxt = ST_IDLE;                // Unused code recovers
      endcase
   end

   // Active configuration update
   always @(posedge clk)
   begin
      if (srst)
      begin
         // Reset clears the word, so all outputs start low
         state_r <= ST_IDLE;
         cfg_r   <= {NB{1'b0}};
      end
      else
      begin
         state_r <= state_nxt;
         // Update edge with shift low, after a finished frame
         if (upd_rise && !sen && state_r == ST_READY)
            cfg_r <= cfg_nxt;
      end
   end

   // Configuration fields
   // Decoded from the active word only, never from the shifter
   wire [1:0] src_a = cfg_r[`CCC_SRC_A_LO+1:`CCC_SRC_A_LO];
   wire [1:0] src_b = cfg_r[`CCC_SRC_B_LO+1:`CCC_SRC_B_LO];
   wire [1:0] src_c = cfg_r[`CCC_SRC_C_LO+1:`CCC_SRC_C_LO];
   wire [1:0] pin_a = cfg_r[`CCC_PIN_A_LO+1:`CCC_PIN_A_LO];
   wire [1:0] pin_b = cfg_r[`CCC_PIN_B_LO+1:`CCC_PIN_B_LO];
   wire [1:0] pin_c = cfg_r[`CCC_PIN_C_LO+1:`CCC_PIN_C_LO];
   wire       pll_en = cfg_r[`CCC_PLL_EN];
   wire       en_glb = cfg_r[`CCC_EN_GLB];
   wire       en_yb  = cfg_r[`CCC_EN_YB];
   wire       en_glc = cfg_r[`CCC_EN_GLC];
   wire       en_yc  = cfg_r[`CCC_EN_YC];

   // Source selection for one global location
   // Out-of-range pin codes give a quiet low rather than an unknown
   function sel_src;
      input [1:0] src;
      input [1:0] pin;
      input [2:0] se;
      input [1:0] df;
      input       core;
      begin
         case (src)
            `CCC_SRC_SE:   sel_src = (pin < SE_PINS) ? se[pin] : 1'b0;
            `CCC_SRC_DIFF: sel_src = (pin < DIFF_PINS) ? df[pin[0]] : 1'b0;
            `CCC_SRC_CORE: sel_src = core;
            default:       sel_src = 1'b0;
         endcase
      end
   endfunction

   wire in_a = sel_src(src_a, pin_a, ref_clock_in_a, diff_in_a, core_clk_a);
   wire in_b = sel_src(src_b, pin_b, clock_in_b, diff_in_b, core_clk_b);
   wire in_c = sel_src(src_c, pin_c, clock_in_c, diff_in_c, core_clk_c);

   // Grouping: C-side outputs need a B-side output
   // Illegal C-without-B keeps B and C off the PLL and raises a flag
   // Sleep low keeps the PLL stopped whatever the word says
   wire b_any   = en_yb | en_glb;
   wire c_any   = en_yc | en_glc;
   wire grp_ok  = !(c_any && !b_any);
   wire pll_on  = pll_en & pll_sleep_n;
   wire b_pll   = pll_on & b_any & grp_ok;
   wire c_pll   = pll_on & c_any & grp_ok;

   // Output stage, all registered
   // Each output is one flop from its source, so glitches stay inside
   always @(posedge clk)
   begin
      if (srst)
      begin
         global_out_a <= 1'b0;
         global_out_b <= 1'b0;
         global_out_c <= 1'b0;
         core_out_b   <= 1'b0;
         core_out_c   <= 1'b0;
         pll_run      <= 1'b0;
         grouping_err <= 1'b0;
      end
      else
      begin
         pll_run      <= pll_on;
         grouping_err <= pll_en & ~grp_ok;
         // Output A: PLL fed by input A, else plain buffer
         global_out_a <= pll_on ? pll_clk : in_a;
         // Output B: core use blocks independent buffer reuse
         if (b_pll)
            global_out_b <= en_glb & pll_clk;
         else
            global_out_b <= (pll_on & en_yb) ? 1'b0 : in_b;
         // Output C: same pattern as B, gated by C-side use
         if (c_pll)
            global_out_c <= en_glc & pll_clk;
         else
            global_out_c <= (pll_on & en_yc) ? 1'b0 : in_c;
         // Core outputs carry the PLL clock only when their side is on the PLL and enabled
         core_out_b   <= b_pll & en_yb & pll_clk;
         core_out_c   <= c_pll & en_yc & pll_clk;
      end
   end

   // Delay and oscillator controls, registered from active config
   // Codes follow the active word one clock later, like the clocks
   always @(posedge clk)
   begin
      if (srst)
      begin
         dly_global_a      <= 4'h0;
         dly_global_b      <= 4'h0;
         dly_global_c      <= 4'h0;
         dly_core_b        <= 6'h00;
         dly_core_c        <= 6'h00;
         dly_feedback      <= 4'h0;
         output_mux_select <= 2'h0;
         osc_half_div_a    <= 1'b0;
         osc_half_div_b    <= 1'b0;
         osc_half_div_c    <= 1'b0;
      end
      else
      begin
         dly_global_a <= cfg_r[`CCC_DLY_GLA_LO+3:`CCC_DLY_GLA_LO];
         dly_global_b <= cfg_r[`CCC_DLY_GLB_LO+3:`CCC_DLY_GLB_LO];
         dly_global_c <= cfg_r[`CCC_DLY_GLC_LO+3:`CCC_DLY_GLC_LO];
         dly_core_b   <= cfg_r[`CCC_DLY_YB_LO+5:`CCC_DLY_YB_LO];
         dly_core_c   <= cfg_r[`CCC_DLY_YC_LO+5:`CCC_DLY_YC_LO];
         dly_feedback <= cfg_r[`CCC_FB_DLY_LO+3:`CCC_FB_DLY_LO];
         output_mux_select <= cfg_r[`CCC_GMUX_HI:`CCC_GMUX_LO];
         // Half division only meaningful with PLL bypassed
         osc_half_div_a <= ~pll_en & cfg_r[`CCC_HALF_A];
         osc_half_div_b <= ~pll_en & cfg_r[`CCC_HALF_B];
         osc_half_div_c <= ~pll_en & cfg_r[`CCC_HALF_C];
      end
   end

endmodule // ccc_config

// file: ccc_config_assertions.sv
// Port checks for the clock conditioner configuration block
`timescale 1ns/1ps
module ccc_config_assertions (
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       shift_enable,
   input wire logic       update_strobe,
   input wire logic       pll_sleep_n,
   input wire logic       pll_run,
   input wire logic       grouping_err,
   input wire logic       global_out_a,
   input wire logic [3:0] dly_global_a,
   input wire logic [5:0] dly_core_c,
   input wire logic [3:0] dly_feedback,
   input wire logic [1:0] output_mux_select,
   input wire logic       osc_half_div_c
);
   wire [13:0] dly_v = {dly_global_a, dly_core_c, dly_feedback}; // Delay codes together
   wire [2:0]  sel_v = {output_mux_select, osc_half_div_c};      // Mux and divider picks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   upd_latency_a: assert property ($changed(dly_v) && !$past(srst) |->
      $past(update_strobe, 4) && !$past(update_strobe, 5))
      else $error("delay codes moved without update");
   sel_latency_a: assert property ($changed(sel_v) && !$past(srst) |->
      $past(update_strobe, 4) && !$past(update_strobe, 5))
      else $error("mux pick moved without update");
   err_timing_a: assert property ($changed(grouping_err) && !$past(srst) |->
      $past(update_strobe, 4) && !$past(update_strobe, 5))
      else $error("grouping flag moved without update");
   shift_hold_a: assert property (shift_enable [*6] |=> $stable(dly_v) && $stable(sel_v))
      else $error("config moved while shifting");
   shift_err_a: assert property (shift_enable [*6] |=> $stable(grouping_err))
      else $error("grouping flag moved while shifting");
   upd_spacing_a: assert property ($changed(dly_v) |=> $stable(dly_v) [*3])
      else $error("held update applied twice");
   pll_sleep_a: assert property (!pll_sleep_n [*3] |-> !pll_run)
      else $error("pll running while asleep");
   reset_clear_a: assert property ($fell(srst) |-> dly_v == 14'h0 && sel_v == 3'h0 &&
      !pll_run && !grouping_err && !global_out_a) else $error("outputs not cleared");
   cover property ($changed(dly_v));
   cover property (shift_enable && update_strobe);
   cover property ($rose(grouping_err));
endmodule // ccc_config_assertions
bind ccc_config ccc_config_assertions chk_u (.clk(clk), .srst(srst),
   .shift_enable(shift_enable), .update_strobe(update_strobe), .pll_sleep_n(pll_sleep_n),
   .pll_run(pll_run), .grouping_err(grouping_err), .global_out_a(global_out_a),
   .dly_global_a(dly_global_a), .dly_core_c(dly_core_c), .dly_feedback(dly_feedback),
   .output_mux_select(output_mux_select), .osc_half_div_c(osc_half_div_c));

// file: ccc_loader.sv
// Loader model that shifts and strobes configuration into the block
`timescale 1ns/1ps
module ccc_loader (
   input  wire clk,
   output reg  serial_config_in = 1'b0,
   output reg  shift_enable = 1'b0,
   output reg  update_strobe = 1'b0
);
   // Full load, MSB first; bad raises a stray strobe mid-shift
   task load(input [88:0] cfg, input integer hold, input bad);
      integer i;
      begin
         for (i = 88; i >= 0; i = i - 1)
         begin
            @(posedge clk);
            shift_enable <= 1'b1;
            serial_config_in <= cfg[i];
            update_strobe <= bad && (i == 40);
         end
         @(posedge clk);
         shift_enable <= 1'b0;
         serial_config_in <= ~serial_config_in;    // Line left moving after the frame
         update_strobe <= 1'b0;
         @(posedge clk);
         update_strobe <= 1'b1;
         repeat (hold) @(posedge clk);
         update_strobe <= 1'b0;
      end
   endtask
endmodule // ccc_loader

// file: ccc_config_tb.sv
// Self-checking bench for the clock conditioner configuration block
`timescale 1ns/1ps
`include "ccc_defs.vh"
module ccc_config_tb;
   reg         clk = 1'b0;          // 50 MHz clock
   reg         srst = 1'b1;         // Synchronous reset
   reg         pll_sleep_n = 1'b0;
   reg  [19:0] src_v = 20'h0;       // All candidate clock inputs
   wire        sdi, sen, upd, ga, gb, gc, yb, yc, pll_run, grouping_err, hda, hdb, hdc;
   wire [3:0]  dga, dgb, dgc, dfb;
   wire [5:0]  dyb, dyc;
   wire [1:0]  mux;
   wire [32:0] outs = {dfb, dyc, dyb, dgc, dgb, dga, mux, hdc, hdb, hda};
   integer     bad_count = 0;
   integer     checks = 0;
   integer     k;
   reg  [88:0] cfg_a, cfg_b, c;
   initial forever #10 clk = ~clk;
   ccc_loader ldr_u (.clk(clk), .serial_config_in(sdi), .shift_enable(sen), .update_strobe(upd));
   ccc_config dut_u (.clk(clk), .srst(srst), .serial_config_in(sdi), .shift_enable(sen),
      .update_strobe(upd), .pll_sleep_n(pll_sleep_n), .ref_clock_in_a(src_v[2:0]),
      .clock_in_b(src_v[5:3]), .clock_in_c(src_v[8:6]), .diff_in_a(src_v[10:9]),
      .diff_in_b(src_v[12:11]), .diff_in_c(src_v[14:13]), .core_clk_a(src_v[15]),
      .core_clk_b(src_v[16]), .core_clk_c(src_v[17]), .pll_clk(src_v[18]), .osc_clk(src_v[19]),
      .global_out_a(ga), .global_out_b(gb), .global_out_c(gc), .core_out_b(yb), .core_out_c(yc),
      .dly_global_a(dga), .dly_global_b(dgb), .dly_global_c(dgc), .dly_core_b(dyb),
      .dly_core_c(dyc), .dly_feedback(dfb), .output_mux_select(mux), .osc_half_div_a(hda),
      .osc_half_div_b(hdb), .osc_half_div_c(hdc), .pll_run(pll_run), .grouping_err(grouping_err));
   // Expected visible fields of a loaded word
   function [32:0] fields_of(input [88:0] v);
      fields_of = {v[`CCC_FB_DLY_LO +: 4], v[`CCC_DLY_YC_LO +: 6], v[`CCC_DLY_YB_LO +: 6],
         v[`CCC_DLY_GLC_LO +: 4], v[`CCC_DLY_GLB_LO +: 4], v[`CCC_DLY_GLA_LO +: 4],
         v[`CCC_GMUX_HI:`CCC_GMUX_LO], v[`CCC_HALF_C], v[`CCC_HALF_B], v[`CCC_HALF_A]};
   endfunction
   task chk(input [63:0] got, input [63:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp)
         begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   // Load, then allow the four-cycle apply latency
   task apply(input [88:0] v, input integer hold);
      begin
         ldr_u.load(v, hold, 1'b0);
         repeat (6) @(posedge clk);
      end
   endtask
   task summarize;
      begin
         $display("checks %0d bad_count %0d", checks, bad_count);
         if (bad_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial
   begin
      cfg_a = 89'h0;
      cfg_a[`CCC_FB_DLY_LO+3:`CCC_DLY_GLA_LO] = 28'h9a5c3e7;
      cfg_a[`CCC_GMUX_HI:`CCC_HALF_A] = 5'h15;
      cfg_b = {~cfg_a[88:17], 17'h0};
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({outs, ga, gb, gc, yb, yc, pll_run, grouping_err}, 40'h0);
      apply(cfg_a, 1);
      chk(outs, fields_of(cfg_a));
      fork
         ldr_u.load(cfg_b, 4, 1'b1);
         begin
            repeat (60) @(posedge clk);
            chk(outs, fields_of(cfg_a));
         end
      join
      repeat (6) @(posedge clk);
      chk(outs, fields_of(cfg_b));
      // Each source kind for output A, single-ended pins 0 and 2 and differential pin 1
      for (k = 0; k < 4; k = k + 1)
      begin
         c = 89'h0;
         c[`CCC_SRC_A_LO +: 2] = (k == 3) ? 2'h0 : k[1:0];
         c[`CCC_PIN_A_LO +: 2] = (k == 3) ? 2'h2 : {1'b0, k[0]};
         c[`CCC_GMUX_HI:`CCC_GMUX_LO] = k[1:0];
         c[`CCC_HALF_A + k % 3] = 1'b1;
         apply(c, 1);
         chk(outs, fields_of(c));
         src_v <= (k == 2) ? 20'h08000 : (k == 1) ? 20'h00400 : (k == 3) ? 20'h4 : 20'h1;
         repeat (4) @(posedge clk);
         chk(ga, 1'b1);
         src_v <= ~src_v;
         repeat (4) @(posedge clk);
         chk(ga, 1'b0);
      end
      // PLL with C but no B, then a legal grouping
      c = 89'h0;
      c[`CCC_PLL_EN] = 1'b1;
      c[`CCC_EN_GLC] = 1'b1;
      src_v <= 20'h40000;
      pll_sleep_n <= 1'b1;
      apply(c, 1);
      chk({grouping_err, ga, gb, gc, yb, yc}, 6'h30);
      c[`CCC_EN_YB] = 1'b1;
      apply(c, 2);
      chk({grouping_err, pll_run, ga, gb, gc, yb, yc}, 7'h36);
      pll_sleep_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk(pll_run, 1'b0);
      apply(cfg_a, 1);
      chk(outs, fields_of(cfg_a));
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({outs, ga, gb, gc, yb, yc, pll_run, grouping_err}, 40'h0);
      summarize;
   end
   // Watchdog against a hung load
   initial
   begin
      repeat (5000) @(posedge clk);
      bad_count = bad_count + 1;
      $display("unexpected at %0t: timeout", $time);
      summarize;
   end
endmodule // ccc_config_tb
